// ---- rtl/phs_defines.svh ----
/*
  Constants of the protector host serial block: slave address, register
  offsets, field positions, key codes and reset values.
  Assumes it is included by bare name from the package and the modules.
*/
// Summary of operation
// - Program pin high-low pulse commits nonvolatile copy
// - Three power states: normal, drain and shutdown
// - Host shutdown bit: discharge off, wait pack zero
// - Autonomous undervoltage: discharge off, then shutdown
// - Pack above wake threshold leaves shutdown
// - Parity mismatch sets flag, alert driven low
// - Autonomous parity fault: switches and open-drain off
// - Host-controlled parity fault: only flag and alert
// - Slave only, never drives serial clock
// - Slave address is binary 0010000
// - General call address is not acknowledged
// - Register pointer never auto-increments
// - Last location kept for repeat access
// - Twelve registers: status, RAM, nonvolatile-backed
// - Nonvolatile registers read back committed copy
// - Parity flag is read-only bit six
// - Mode bit: 0 autonomous default, 1 host
`ifndef PHS_DEFINES_SVH
`define PHS_DEFINES_SVH

// ======
// Serial link
`define PHS_SLAVE_ADDR 7'h10

// ======
// Register offsets
`define PHS_REG_STATUS 8'h00
`define PHS_REG_OUTPUT 8'h01
`define PHS_REG_STATE 8'h02
`define PHS_REG_FEATURE 8'h03
`define PHS_REG_BYPASS 8'h04
`define PHS_REG_MONITOR 8'h05
`define PHS_REG_NV_FIRST 8'h06
`define PHS_REG_NV_LAST 8'h0A
`define PHS_REG_NVM_ENABLE 8'h0B
`define PHS_NV_COUNT 5

// ======
// Field positions
`define PHS_OUT_DSG_BIT 1
`define PHS_OUT_CHG_BIT 2
`define PHS_OUT_GENERAL_OPEN_DRAIN_OUT_BIT 3
`define PHS_OUT_PFAULT_BIT 6
`define PHS_ST_SHUTDOWN_REQUEST_BIT 0
`define PHS_ST_HOST_BIT 1
`define PHS_FLAG_SCD_BIT 0
`define PHS_FLAG_OCD_BIT 1
`define PHS_FLAG_OV_BIT 2
`define PHS_FLAG_OVTEMP_BIT 3
`define PHS_FLAG_VGOOD_BIT 4
`define PHS_OUT_WMASK 8'h8F
`define PHS_STATE_WMASK 8'hC3

// ======
// Nonvolatile enable codes and their read-back
`define PHS_NVM_KEY_PROG 8'hE2
`define PHS_NVM_READ_PROG 8'h62
`define PHS_NVM_KEY_ALT 8'h41

// ======
// Reset values
`define PHS_RST_RAM 8'h00
`define PHS_RST_NV 8'h00

`endif

// ---- rtl/phs_pkg.sv ----
/*
  Types of the protector host serial block: power and link states and
  the packed state records of both modules.
  Assumes phs_defines.svh is on the include path.
*/
`include "phs_defines.svh"

package phs_pkg;

    typedef enum logic [1:0] {
        PHS_PWR_NORMAL = 2'b00,
        PHS_PWR_DRAIN = 2'b01,
        PHS_PWR_SHUT = 2'b10
    } phs_power_t;

    typedef enum logic [1:0] {
        PHS_LNK_IDLE = 2'b00,
        PHS_LNK_ADDR = 2'b01,
        PHS_LNK_RX = 2'b10,
        PHS_LNK_TX = 2'b11
    } phs_link_phase_t;

    typedef struct packed {
        phs_link_phase_t phase;
        logic [3:0] cnt;
        logic [7:0] shreg;
        logic rd;
        logic first;
        logic drive;
        logic fall_seen;
        logic en_s1;
        logic en_s2;
        logic [7:0] ptr;
        logic ptr_tgl;
        logic [7:0] wr_data;
        logic wr_tgl;
        logic snap_tgl;
    } phs_link_state_t;

    typedef struct packed {
        logic [9:0] pin_s1;
        logic [9:0] pin_s2;
        logic [2:0] tgl_s1;
        logic [2:0] tgl_s2;
        logic [2:0] tgl_s3;
        logic refresh;
        logic prog_prev;
        phs_power_t power;
        logic [7:0] out_ctl;
        logic [7:0] state_ctl;
        logic [7:0] feature;
        logic [7:0] bypass;
        logic [7:0] monitor;
        logic [`PHS_NV_COUNT-1:0][7:0] nv_stage;
        logic [`PHS_NV_COUNT-1:0][7:0] nv;
        logic [7:0] nvm_rd;
        logic nvm_supply;
        logic commit;
        logic parity_flag;
        logic chg_drv;
        logic dsg_drv;
        logic general_open_drain_out_oe;
        logic alert_n;
        logic shut;
        logic [7:0] rd_word;
        logic link_en;
    } phs_core_state_t;

endpackage : phs_pkg

// ---- rtl/phs_link_if.sv ----
/*
  Carrier between the serial link engine (host clock) and the register
  core (core clock). Words are qualified by toggles; see the two modules.
  Assumes both ends sit in one top module.
*/
`timescale 1ns/1ps

interface phs_link_if;
    logic [7:0] ptr;
    logic ptr_tgl;
    logic [7:0] wr_data;
    logic wr_tgl;
    logic snap_tgl;
    logic [7:0] rd_word;
    logic link_en;

    modport link (output ptr, output ptr_tgl, output wr_data, output wr_tgl,
                  output snap_tgl, input rd_word, input link_en);
    modport core (input ptr, input ptr_tgl, input wr_data, input wr_tgl,
                  input snap_tgl, output rd_word, output link_en);
endinterface : phs_link_if

// ---- rtl/phs_serial_link.sv ----
/*
  Two-wire slave engine clocked by the host serial clock.
  Assumes an open-drain bus resolved outside and a core that holds
  rd_word steady while a byte is shifted out.
*/
`timescale 1ns/1ps

module phs_serial_link (
    // Clock and reset
    input wire logic scl_clk_in,
    input wire logic sys_rst_in,
    // Data line
    input wire logic sda_in,
    output logic sda_oe_out,
    // Core side
    phs_link_if.link lnk
);
    import phs_pkg::*;

    phs_link_state_t st_reg;
    phs_link_state_t st_next;
    logic fall_tgl_reg;
    logic fall_scl_reg;
    logic [7:0] byte_in;

    // ======
    // Start marker
    // Clocked by the data line: a stop and the next start share one
    // clock-high phase, so clock edges alone cannot see the start.
    always_ff @(negedge sda_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            fall_tgl_reg <= 1'b0;
            fall_scl_reg <= 1'b0;
        end else begin
            fall_tgl_reg <= ~fall_tgl_reg;
            fall_scl_reg <= scl_clk_in;
        end
    end

    // ======
    // Bit engine
    always_comb begin
        st_next = st_reg;
        byte_in = {st_reg.shreg[6:0], sda_in};
        st_next.en_s1 = lnk.link_en;
        st_next.en_s2 = st_reg.en_s1;
        st_next.fall_seen = fall_tgl_reg;
        if ((fall_tgl_reg != st_reg.fall_seen) && fall_scl_reg) begin
            st_next.phase = PHS_LNK_ADDR;
            st_next.shreg = {7'h00, sda_in};
            st_next.cnt = 4'h1;
            st_next.drive = 1'b0;
            st_next.snap_tgl = ~st_reg.snap_tgl;
        end else if (st_reg.phase != PHS_LNK_IDLE) begin
            if (st_reg.cnt == 4'h8) begin
                st_next.cnt = 4'h0;
                st_next.drive = 1'b0;
                if (st_reg.phase == PHS_LNK_ADDR) begin
                    st_next.phase = st_reg.rd ? PHS_LNK_TX : PHS_LNK_RX;
                    st_next.first = 1'b1;
                end
                if ((st_reg.phase == PHS_LNK_TX) && sda_in) begin
                    st_next.phase = PHS_LNK_IDLE;
                end else if (st_reg.rd) begin
                    st_next.shreg = lnk.rd_word;
                    st_next.drive = ~lnk.rd_word[7];
                end
            end else if (st_reg.phase == PHS_LNK_TX) begin
                st_next.cnt = st_reg.cnt + 4'h1;
                st_next.shreg = {st_reg.shreg[6:0], 1'b0};
                st_next.drive = (st_reg.cnt != 4'h7) && !st_reg.shreg[6];
            end else begin
                st_next.cnt = st_reg.cnt + 4'h1;
                st_next.shreg = byte_in;
                if ((st_reg.cnt == 4'h7) && (st_reg.phase == PHS_LNK_ADDR)) begin
                    st_next.rd = byte_in[0];
                    st_next.drive = st_reg.en_s2 && (byte_in[7:1] == `PHS_SLAVE_ADDR);
                    if (!st_next.drive) begin
                        st_next.phase = PHS_LNK_IDLE;
                    end
                end else if (st_reg.cnt == 4'h7) begin
                    st_next.drive = 1'b1;
                    st_next.first = 1'b0;
                    if (st_reg.first) begin
                        st_next.ptr = byte_in;
                        st_next.ptr_tgl = ~st_reg.ptr_tgl;
                    end else begin
                        st_next.wr_data = byte_in;
                        st_next.wr_tgl = ~st_reg.wr_tgl;
                    end
                end
            end
        end
    end

    always_ff @(posedge scl_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    // Data changes only while the clock is low; the clock is never driven
    always_ff @(negedge scl_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            sda_oe_out <= 1'b0;
        end else begin
            sda_oe_out <= st_reg.drive;
        end
    end

    assign lnk.ptr = st_reg.ptr;
    assign lnk.ptr_tgl = st_reg.ptr_tgl;
    assign lnk.wr_data = st_reg.wr_data;
    assign lnk.wr_tgl = st_reg.wr_tgl;
    assign lnk.snap_tgl = st_reg.snap_tgl;

endmodule : phs_serial_link

// ---- rtl/phs_protector_regs.sv ----
/*
  Top of the protector host serial block: register set, nonvolatile
  staging and commit, parity reaction, power modes and switch drives.
  Assumes analog conditions arrive as levels from another domain and
  the host clock only runs during transfers.
*/
`timescale 1ns/1ps
`include "phs_defines.svh"

module phs_protector_regs (
    // Core clock and reset
    input wire logic core_clk_in,
    input wire logic sys_rst_in,
    // Serial link, clocked by the host
    input wire logic scl_clk_in,
    input wire logic serial_data_line_in,
    output logic serial_data_line_out,
    output logic serial_data_line_oe_out,
    // Nonvolatile programming
    input wire logic nvm_program_pin_in,
    input wire logic nvm_parity_error_in,
    output logic nvm_supply_en_out,
    output logic nvm_commit_out,
    // Analog front end conditions
    input wire logic undervoltage_detect_in,
    input wire logic pack_at_zero_in,
    input wire logic pack_above_wake_in,
    input wire logic [4:0] protect_flags_in,
    // Switch, alert and open-drain pins
    output logic charge_switch_drive_out,
    output logic discharge_switch_drive_out,
    output logic general_open_drain_out,
    output logic general_open_drain_oe_out,
    output logic fault_alert_n_out,
    output logic shutdown_out
);
    import phs_pkg::*;

    phs_core_state_t st_reg;
    phs_core_state_t st_next;
    phs_link_if lnk ();

    logic [4:0] flags;
    logic uv;
    logic prog_pin;
    logic pack_zero;
    logic pack_wake;
    logic parity_err;
    logic wr_evt;
    logic ptr_evt;
    logic snap_evt;
    logic host_mode;
    logic faults;
    logic chg_on;
    logic dsg_on;

    // ======
    // Decode helpers
    function automatic logic phs_is_nv(input logic [7:0] p);
        phs_is_nv = (p >= `PHS_REG_NV_FIRST) && (p <= `PHS_REG_NV_LAST);
    endfunction : phs_is_nv

    function automatic logic [2:0] phs_nv_index(input logic [7:0] p);
        logic [7:0] d;
        d = p - `PHS_REG_NV_FIRST;
        phs_nv_index = d[2:0];
    endfunction : phs_nv_index

    // Nonvolatile-backed registers answer with the committed copy,
    // so a write reads back only after programming has run.
    function automatic logic [7:0] phs_reg_value(input phs_core_state_t s, input logic [7:0] p);
        logic [4:0] f;
        f = s.pin_s2[4:0];
        phs_reg_value = 8'h00;
        if (p == `PHS_REG_STATUS) begin
            phs_reg_value = {~s.chg_drv, ~s.dsg_drv, f[`PHS_FLAG_VGOOD_BIT], f[`PHS_FLAG_OVTEMP_BIT],
                             s.pin_s2[6], f[`PHS_FLAG_OV_BIT], f[`PHS_FLAG_OCD_BIT], f[`PHS_FLAG_SCD_BIT]};
        end else if (p == `PHS_REG_OUTPUT) begin
            phs_reg_value = s.out_ctl;
            phs_reg_value[`PHS_OUT_PFAULT_BIT] = s.parity_flag;
        end else if (p == `PHS_REG_STATE) begin
            phs_reg_value = s.state_ctl;
        end else if (p == `PHS_REG_FEATURE) begin
            phs_reg_value = s.feature;
        end else if (p == `PHS_REG_BYPASS) begin
            phs_reg_value = s.bypass;
        end else if (p == `PHS_REG_MONITOR) begin
            phs_reg_value = s.monitor;
        end else if (phs_is_nv(p)) begin
            phs_reg_value = s.nv[phs_nv_index(p)];
        end else if (p == `PHS_REG_NVM_ENABLE) begin
            phs_reg_value = s.nvm_rd;
        end
    endfunction : phs_reg_value

    // ======
    // Serial link engine on the host clock
    phs_serial_link u_link (
        .scl_clk_in(scl_clk_in),
        .sys_rst_in(sys_rst_in),
        .sda_in(serial_data_line_in),
        .sda_oe_out(serial_data_line_oe_out),
        .lnk(lnk.link)
    );

    // Open drain: the line is only ever pulled low
    assign serial_data_line_out = 1'b0;
    assign general_open_drain_out = 1'b0;

    // ======
    // Synchronised views
    assign flags = st_reg.pin_s2[4:0];
    assign prog_pin = st_reg.pin_s2[5];
    assign uv = st_reg.pin_s2[6];
    assign pack_zero = st_reg.pin_s2[7];
    assign pack_wake = st_reg.pin_s2[8];
    assign parity_err = st_reg.pin_s2[9];
    assign wr_evt = st_reg.tgl_s2[0] ^ st_reg.tgl_s3[0];
    assign ptr_evt = st_reg.tgl_s2[1] ^ st_reg.tgl_s3[1];
    assign snap_evt = st_reg.tgl_s2[2] ^ st_reg.tgl_s3[2];
    assign host_mode = st_reg.state_ctl[`PHS_ST_HOST_BIT];
    assign faults = (|flags[`PHS_FLAG_OVTEMP_BIT:`PHS_FLAG_SCD_BIT]) || uv;

    // ======
    // Switch decisions
    always_comb begin
        if (st_reg.power == PHS_PWR_SHUT) begin
            chg_on = 1'b0;
            dsg_on = 1'b0;
        end else if (host_mode) begin
            // Parity faults leave the switches to the host
            chg_on = st_reg.out_ctl[`PHS_OUT_CHG_BIT];
            dsg_on = st_reg.out_ctl[`PHS_OUT_DSG_BIT] && (st_reg.power == PHS_PWR_NORMAL);
        end else begin
            chg_on = !(flags[`PHS_FLAG_OV_BIT] || flags[`PHS_FLAG_OVTEMP_BIT] || st_reg.parity_flag);
            dsg_on = !(uv || flags[`PHS_FLAG_OCD_BIT] || flags[`PHS_FLAG_SCD_BIT]
                       || flags[`PHS_FLAG_OVTEMP_BIT] || st_reg.parity_flag)
                     && (st_reg.power == PHS_PWR_NORMAL);
        end
    end

    // ======
    // Core state
    always_comb begin
        st_next = st_reg;
        st_next.commit = 1'b0;
        st_next.pin_s1 = {nvm_parity_error_in, pack_above_wake_in, pack_at_zero_in,
                          undervoltage_detect_in, nvm_program_pin_in, protect_flags_in};
        st_next.pin_s2 = st_reg.pin_s1;
        st_next.tgl_s1 = {lnk.snap_tgl, lnk.ptr_tgl, lnk.wr_tgl};
        st_next.tgl_s2 = st_reg.tgl_s1;
        st_next.tgl_s3 = st_reg.tgl_s2;
        st_next.prog_prev = prog_pin;
        st_next.refresh = wr_evt || ptr_evt || snap_evt;

        // Power modes
        case (st_reg.power)
            PHS_PWR_NORMAL: begin
                if (host_mode ? st_reg.state_ctl[`PHS_ST_SHUTDOWN_REQUEST_BIT] : uv) begin
                    st_next.power = PHS_PWR_DRAIN;
                end
            end
            PHS_PWR_DRAIN: begin
                if (pack_zero) begin
                    st_next.power = PHS_PWR_SHUT;
                end
            end
            PHS_PWR_SHUT: begin
                if (pack_wake) begin
                    st_next.power = PHS_PWR_NORMAL;
                end
            end
            default: begin
                st_next.power = PHS_PWR_NORMAL;
            end
        endcase

        // Register writes; the pointer stays where the host left it
        if (wr_evt && (st_reg.power != PHS_PWR_SHUT)) begin
            if (lnk.ptr == `PHS_REG_OUTPUT) begin
                st_next.out_ctl = lnk.wr_data & `PHS_OUT_WMASK;
            end else if (lnk.ptr == `PHS_REG_STATE) begin
                st_next.state_ctl = lnk.wr_data & `PHS_STATE_WMASK;
            end else if (lnk.ptr == `PHS_REG_FEATURE) begin
                st_next.feature = lnk.wr_data;
            end else if (lnk.ptr == `PHS_REG_BYPASS) begin
                st_next.bypass = lnk.wr_data;
            end else if (lnk.ptr == `PHS_REG_MONITOR) begin
                st_next.monitor = lnk.wr_data;
            end else if (phs_is_nv(lnk.ptr)) begin
                st_next.nv_stage[phs_nv_index(lnk.ptr)] = lnk.wr_data;
            end else if (lnk.ptr == `PHS_REG_NVM_ENABLE) begin
                st_next.nvm_supply = (lnk.wr_data == `PHS_NVM_KEY_PROG);
                if (lnk.wr_data == `PHS_NVM_KEY_PROG) begin
                    st_next.nvm_rd = `PHS_NVM_READ_PROG;
                end else if (lnk.wr_data == `PHS_NVM_KEY_ALT) begin
                    st_next.nvm_rd = `PHS_NVM_KEY_ALT;
                end else begin
                    st_next.nvm_rd = `PHS_RST_RAM;
                end
            end
        end

        // Commit on the falling edge of the program pin, supply enabled
        if (st_reg.prog_prev && !prog_pin && st_reg.nvm_supply && (st_reg.power != PHS_PWR_SHUT)) begin
            st_next.nv = st_reg.nv_stage;
            st_next.commit = 1'b1;
        end

        // Parity mismatch is sticky until shutdown or reset
        if (parity_err) begin
            st_next.parity_flag = 1'b1;
        end

        // Read word for the link; changes only after a link event or in shutdown
        if (st_reg.refresh) begin
            st_next.rd_word = phs_reg_value(st_reg, lnk.ptr);
        end

        // Pins
        st_next.chg_drv = !chg_on;
        st_next.dsg_drv = !dsg_on;
        st_next.general_open_drain_out_oe = st_reg.out_ctl[`PHS_OUT_GENERAL_OPEN_DRAIN_OUT_BIT] && !(!host_mode && st_reg.parity_flag)
                          && (st_reg.power != PHS_PWR_SHUT);
        st_next.alert_n = !(st_reg.parity_flag || faults) || (st_reg.power == PHS_PWR_SHUT);
        st_next.shut = (st_reg.power == PHS_PWR_SHUT);
        st_next.link_en = (st_reg.power != PHS_PWR_SHUT);

        // Shutdown: contents are lost, everything stays off
        if (st_reg.power == PHS_PWR_SHUT) begin
            st_next.out_ctl = `PHS_RST_RAM;
            st_next.state_ctl = `PHS_RST_RAM;
            st_next.feature = `PHS_RST_RAM;
            st_next.bypass = `PHS_RST_RAM;
            st_next.monitor = `PHS_RST_RAM;
            st_next.nvm_rd = `PHS_RST_RAM;
            st_next.nvm_supply = 1'b0;
            st_next.parity_flag = 1'b0;
            st_next.rd_word = `PHS_RST_RAM;
            for (int i = 0; i < `PHS_NV_COUNT; i++) begin
                st_next.nv_stage[i] = `PHS_RST_NV;
                st_next.nv[i] = `PHS_RST_NV;
            end
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            st_reg <= '0;
            st_reg.chg_drv <= 1'b1;
            st_reg.dsg_drv <= 1'b1;
            st_reg.alert_n <= 1'b1;
        end else begin
            st_reg <= st_next;
        end
    end

    // ======
    // Outputs
    assign lnk.rd_word = st_reg.rd_word;
    assign lnk.link_en = st_reg.link_en;
    assign nvm_supply_en_out = st_reg.nvm_supply;
    assign nvm_commit_out = st_reg.commit;
    assign charge_switch_drive_out = st_reg.chg_drv;
    assign discharge_switch_drive_out = st_reg.dsg_drv;
    assign general_open_drain_oe_out = st_reg.general_open_drain_out_oe;
    assign fault_alert_n_out = st_reg.alert_n;
    assign shutdown_out = st_reg.shut;

endmodule : phs_protector_regs

// ---- testbench/phs_assertions.sv ----
/*
  Checker of the protector register block, bound to its top module.
  Assumes core-clock sampling and the synchronous high reset.
*/
`timescale 1ns/1ps

module phs_assertions (
    // Clock and reset
    input wire logic core_clk_in,
    input wire logic sys_rst_in,
    // Watched inputs
    input wire logic nvm_parity_error_in,
    input wire logic pack_above_wake_in,
    // Watched outputs
    input wire logic serial_data_line_oe_out,
    input wire logic nvm_supply_en_out,
    input wire logic nvm_commit_out,
    input wire logic charge_switch_drive_out,
    input wire logic discharge_switch_drive_out,
    input wire logic general_open_drain_oe_out,
    input wire logic fault_alert_n_out,
    input wire logic shutdown_out
);
    // ======
    // Properties
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (sys_rst_in);

    chk_commit_single: assert property (nvm_commit_out |=> !nvm_commit_out)
        else $error("long commit");
    chk_commit_supply: assert property (nvm_commit_out |-> nvm_supply_en_out)
        else $error("commit unpowered");
    chk_parity_alert: assert property (($rose(nvm_parity_error_in) && !shutdown_out)
        |-> ##[1:6] !fault_alert_n_out)
        else $error("no parity alert");
    chk_shut_drives: assert property (shutdown_out |-> discharge_switch_drive_out && charge_switch_drive_out)
        else $error("switch on in shutdown");
    chk_shut_quiet: assert property (shutdown_out |-> fault_alert_n_out && !general_open_drain_oe_out)
        else $error("pin active in shutdown");
    chk_shut_link: assert property (shutdown_out |-> !serial_data_line_oe_out)
        else $error("data line pulled during shutdown");
    chk_wake_exit: assert property (($rose(pack_above_wake_in) && shutdown_out) |-> ##[1:6] !shutdown_out)
        else $error("no exit from shutdown on wake");
    chk_drain_first: assert property ($rose(shutdown_out) |-> $past(discharge_switch_drive_out))
        else $error("early shutdown");

    cover property ($rose(shutdown_out));
    cover property (nvm_commit_out);
    cover property ($fell(fault_alert_n_out));
endmodule : phs_assertions

bind phs_protector_regs phs_assertions u_chk (.*);

// ---- testbench/phs_host_model.sv ----
/*
  Host bus master model: drives the serial clock only inside frames.
  Assumes a pulled-up data line resolved by the bench.
*/
`timescale 1ns/1ps

module phs_host_model (
    // Bus lines
    output logic scl_out,
    output logic sda_out,
    input wire logic sda_in
);
    // ======
    // Bit level, 125 ns per bit
    initial begin
        scl_out = 1'b1;
        sda_out = 1'b1;
    end

    task automatic clk_bit(input logic b, output logic r);
        sda_out = b;
        #31 scl_out = 1'b1;
        #31 r = sda_in;
        #32 scl_out = 1'b0;
        #31;
    endtask : clk_bit

    task automatic start_f();
        #62 sda_out = 1'b0;
        #62 scl_out = 1'b0;
    endtask : start_f

    task automatic stop_f();
        sda_out = 1'b0;
        #31 scl_out = 1'b1;
        #62 sda_out = 1'b1;
        #62;
    endtask : stop_f

    // ======
    // Byte level, most significant bit first
    task automatic send(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) clk_bit(d[i], r);
        clk_bit(1'b1, r);
        ack = !r;
    endtask : send

    task automatic recv(input logic last, output logic [7:0] q);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            clk_bit(1'b1, r);
            q[i] = r;
        end
        clk_bit(last, r);
    endtask : recv
endmodule : phs_host_model

// ---- testbench/tb.sv ----
/*
  Self-checking bench of the protector register block.
  Assumes the host model and checker files are compiled before it.
*/
`timescale 1ns/1ps

module tb;
    logic core_clk, scl, host_sda, sys_rst, prog_pin, par_err, uv_det, pack_zero, wake;
    logic sda_oe, sup_en, commit, chg_drv, dsg_drv, general_open_drain_out_oe, alert_n, shut, ak;
    logic [7:0] q;
    int fail_count = 0;
    int checks = 0;
    // Pull-up: a released line reads high
    wire sda_line = host_sda & ~sda_oe;

    phs_protector_regs u_dut (.core_clk_in(core_clk), .sys_rst_in(sys_rst), .scl_clk_in(scl),
        .serial_data_line_in(sda_line), .serial_data_line_out(), .serial_data_line_oe_out(sda_oe),
        .nvm_program_pin_in(prog_pin), .nvm_parity_error_in(par_err), .nvm_supply_en_out(sup_en),
        .nvm_commit_out(commit), .undervoltage_detect_in(uv_det), .pack_at_zero_in(pack_zero),
        .pack_above_wake_in(wake), .protect_flags_in(5'h00), .charge_switch_drive_out(chg_drv),
        .discharge_switch_drive_out(dsg_drv), .general_open_drain_out(),
        .general_open_drain_oe_out(general_open_drain_out_oe), .fault_alert_n_out(alert_n), .shutdown_out(shut));
    phs_host_model u_host (.scl_out(scl), .sda_out(host_sda), .sda_in(sda_line));

    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end

    // ======
    // Tasks
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk);
    endtask : cyc

    task automatic wr(input logic [7:0] p, input logic [7:0] d);
        logic a;
        u_host.start_f();
        u_host.send(8'h20, a);
        chk({7'h00, a}, 8'h01);
        u_host.send(p, a);
        u_host.send(d, a);
        u_host.stop_f();
        #1000;
    endtask : wr

    task automatic rd(input logic [7:0] p, input logic [7:0] e);
        logic a;
        logic [7:0] v;
        u_host.start_f();
        u_host.send(8'h20, a);
        u_host.send(p, a);
        u_host.stop_f();
        #1000;
        u_host.start_f();
        u_host.send(8'h21, a);
        u_host.recv(1'b1, v);
        u_host.stop_f();
        #1000;
        chk(v, e);
    endtask : rd

    task automatic rst_dut();
        cyc(1);
        sys_rst <= 1'b1;
        cyc(10);
        sys_rst <= 1'b0;
        #2000;
    endtask : rst_dut

    task automatic summarize();
        $display("checks=%0d fail_count=%0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : summarize

    // ======
    // Sequence
    initial begin
        {sys_rst, prog_pin, par_err, uv_det, pack_zero, wake} = 6'h20;
        rst_dut();
        for (int i = 3; i < 6; i++) begin
            wr(i[7:0], 8'hA5 + i[7:0]);
            rd(i[7:0], 8'hA5 + i[7:0]);
        end
        wr(8'h0C, 8'h77);
        rd(8'h03, 8'hA8);
        wr(8'h00, 8'hFF);
        rd(8'h00, 8'hC0);
        wr(8'h01, 8'hFF);
        rd(8'h01, 8'h8F);
        wr(8'h02, 8'hFC);
        rd(8'h02, 8'hC0);
        $display("register access test done");
        u_host.start_f();
        u_host.send(8'h20, ak);
        u_host.send(8'h03, ak);
        u_host.send(8'h11, ak);
        u_host.send(8'h22, ak);
        u_host.stop_f();
        #1000;
        rd(8'h04, 8'hA9);
        rd(8'h03, 8'h22);
        u_host.start_f();
        u_host.send(8'h21, ak);
        u_host.recv(1'b0, q);
        chk(q, 8'h22);
        u_host.recv(1'b1, q);
        chk(q, 8'h22);
        u_host.stop_f();
        for (int i = 0; i < 2; i++) begin
            u_host.start_f();
            u_host.send(i ? 8'h22 : 8'h00, ak);
            u_host.stop_f();
            chk({7'h00, ak}, 8'h00);
        end
        $display("pointer and address test done");
        wr(8'h06, 8'h5A);
        rd(8'h06, 8'h00);
        wr(8'h0B, 8'hE2);
        rd(8'h0B, 8'h62);
        chk({7'h00, sup_en}, 8'h01);
        cyc(1);
        prog_pin <= 1'b1;
        cyc(4);
        prog_pin <= 1'b0;
        q = 8'h00;
        repeat (12) @(negedge core_clk) q = q | {7'h00, commit};
        chk(q, 8'h01);
        rd(8'h06, 8'h5A);
        wr(8'h0B, 8'h41);
        rd(8'h0B, 8'h41);
        wr(8'h0B, 8'h33);
        rd(8'h0B, 8'h00);
        chk({7'h00, sup_en}, 8'h00);
        $display("nonvolatile test done");
        wr(8'h02, 8'h02);
        wr(8'h01, 8'h0E);
        cyc(1);
        par_err <= 1'b1;
        cyc(8);
        chk({4'h0, alert_n, dsg_drv, chg_drv, general_open_drain_out_oe}, 8'h01);
        rd(8'h01, 8'h4E);
        cyc(1);
        par_err <= 1'b0;
        rst_dut();
        wr(8'h01, 8'h08);
        cyc(1);
        par_err <= 1'b1;
        cyc(8);
        chk({4'h0, alert_n, dsg_drv, chg_drv, general_open_drain_out_oe}, 8'h06);
        par_err <= 1'b0;
        rst_dut();
        $display("parity test done");
        wr(8'h02, 8'h03);
        cyc(8);
        chk({6'h00, shut, dsg_drv}, 8'h01);
        pack_zero <= 1'b1;
        cyc(8);
        chk({6'h00, shut, dsg_drv}, 8'h03);
        u_host.start_f();
        u_host.send(8'h20, ak);
        u_host.stop_f();
        chk({7'h00, ak}, 8'h00);
        cyc(1);
        pack_zero <= 1'b0;
        wake <= 1'b1;
        cyc(8);
        chk({6'h00, shut, dsg_drv}, 8'h00);
        wake <= 1'b0;
        rd(8'h03, 8'h00);
        cyc(1);
        uv_det <= 1'b1;
        cyc(8);
        chk({6'h00, shut, dsg_drv}, 8'h01);
        pack_zero <= 1'b1;
        cyc(8);
        chk({6'h00, shut, dsg_drv}, 8'h03);
        $display("power mode test done");
        summarize();
    end
endmodule : tb
